// ### core/ppfs_defines.vh
`ifndef PPFS_DEFINES_VH
`define PPFS_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the bus
`define PPFS_OFS_PA_UPPER  5'h00
`define PPFS_OFS_PA_LOWER  5'h04
`define PPFS_OFS_PB_DIR    5'h08
`define PPFS_OFS_PB_UPPER  5'h0C
`define PPFS_OFS_PB_LOWER  5'h10

// Power-on reset values
`define PPFS_RST_PA_UPPER  16'h3302
`define PPFS_RST_PA_LOWER  16'hFF95
`define PPFS_RST_PB_DIR    16'h0000
`define PPFS_RST_PB_UPPER  16'h0000
`define PPFS_RST_PB_LOWER  16'h0000

// Reserved bits forced to one
`define PPFS_RSV_PA_UPPER  16'h0002
`define PPFS_RSV_PA_LOWER  16'hAA00

// Field low bits, port A upper select
`define PPFS_PA15_LSB 14
`define PPFS_PA14_LSB 12
`define PPFS_PA13_LSB 10
`define PPFS_PA12_LSB 8
`define PPFS_PA11_LSB 6
`define PPFS_PA10_LSB 4
`define PPFS_PA9_LSB  2
`define PPFS_PA8_BIT  0
// Field low bits, port A lower select
`define PPFS_PA7_BIT  14
`define PPFS_PA6_BIT  12
`define PPFS_PA5_BIT  10
`define PPFS_PA4_BIT  8
`define PPFS_PA3_LSB  6
`define PPFS_PA2_LSB  4
`define PPFS_PA1_LSB  2
`define PPFS_PA0_LSB  0

// Two-bit select codes
`define PPFS_SEL_GPIO 2'h0
`define PPFS_SEL_F1   2'h1
`define PPFS_SEL_F2   2'h2
`define PPFS_SEL_F3   2'h3

`endif

// ### core/ppfs_top.v
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "ppfs_defines.vh"

module ppfs_top (
	input  wire        clock,
	input  wire        rstn,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// Port A pins
	input  wire [15:0] pa_pin_lvl,
	output wire [15:0] pa_pin_drv,
	output wire [15:0] pa_pin_oe,
	// Port B pins
	input  wire [15:0] pb_pin_lvl,
	output wire [15:0] pb_pin_drv,
	output wire [15:0] pb_pin_oe,
	// Port data register side
	input  wire [15:0] pa_dir,
	input  wire [15:0] pa_gpio_dout,
	output wire [15:0] pa_gpio_mode,
	input  wire [15:0] pb_gpio_dout,
	output wire [15:0] pb_gpio_mode,
	output wire [15:0] port_b_direction,
	// Interrupt and DMA
	output wire [7:0]  ext_interrupt,
	output wire        dma_request_in_1,
	output wire        dma_request_in_0,
	input  wire        dma_acknowledge_out_1,
	input  wire        dma_acknowledge_out_0,
	// Timer
	output wire        timer_ext_clock_a,
	output wire        timer_ext_clock_b,
	input  wire        timer1_capcomp_a_drv,
	output wire        timer1_capcomp_a_rcv,
	input  wire        timer1_capcomp_b_drv,
	output wire        timer1_capcomp_b_rcv,
	input  wire        timer0_capcomp_a_drv,
	output wire        timer0_capcomp_a_rcv,
	input  wire        timer0_capcomp_b_drv,
	output wire        timer0_capcomp_b_rcv,
	input  wire [7:0]  pb_timer_drv,
	output wire [7:0]  pb_timer_rcv,
	// Bus controller
	input  wire        upper_parity_bit_drv,
	input  wire        upper_parity_bit_oe,
	output wire        upper_parity_bit_rcv,
	input  wire        lower_parity_bit_drv,
	input  wire        lower_parity_bit_oe,
	output wire        lower_parity_bit_rcv,
	input  wire        address_hold_out,
	output wire        converter_trigger_in,
	input  wire        interrupt_request_out,
	output wire        bus_request_in,
	input  wire        bus_grant_ack,
	input  wire        read_strobe,
	input  wire        upper_write_strobe,
	input  wire        lower_write_strobe,
	input  wire        chip_select_7,
	input  wire        chip_select_6,
	input  wire        chip_select_5,
	input  wire        chip_select_4,
	output wire        wait_state_in,
	input  wire        row_addr_strobe,
	// Serial and pattern
	input  wire        serial_clock_ch1_drv,
	output wire        serial_clock_ch1_rcv,
	input  wire        serial_clock_ch0_drv,
	output wire        serial_clock_ch0_rcv,
	input  wire        serial_tx_ch1,
	input  wire        serial_tx_ch0,
	output wire        serial_rx_ch1,
	output wire        serial_rx_ch0,
	input  wire [15:0] pattern_out
);

////////////////////////////////////////////////////////////////////////////////
// Select registers

reg  [15:0] pa_up_r;     // Port A upper select
reg  [15:0] pa_lo_r;     // Port A lower select
reg  [15:0] pb_dir_r;    // Port B direction
reg  [15:0] pb_up_r;     // Port B upper select
reg  [15:0] pb_lo_r;     // Port B lower select
reg         ack_r;       // Bus answer phase
reg  [31:0] rdata_r;     // Read data holding
reg  [31:0] rd_mux;      // Read data selection
wire        bus_req;     // Any request pending
wire        wr_go;       // Write commits now

assign bus_req         = avs_read | avs_write;
assign avs_waitrequest = bus_req & ~ack_r;
assign wr_go           = avs_write & ack_r;
assign avs_readdata    = rdata_r;
assign port_b_direction = pb_dir_r;

// Byte-lane merge of a write into a 16-bit register
function [15:0] merge16;
	input [15:0] cur;
	input [31:0] wd;
	input [3:0]  be;
	begin
		merge16 = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
	end
endfunction

// Read mux; unmapped offsets read zero
always @* begin
	case (avs_address)
		`PPFS_OFS_PA_UPPER: rd_mux = {16'h0000, pa_up_r | `PPFS_RSV_PA_UPPER};
		`PPFS_OFS_PA_LOWER: rd_mux = {16'h0000, pa_lo_r | `PPFS_RSV_PA_LOWER};
		`PPFS_OFS_PB_DIR:   rd_mux = {16'h0000, pb_dir_r};
		`PPFS_OFS_PB_UPPER: rd_mux = {16'h0000, pb_up_r};
		`PPFS_OFS_PB_LOWER: rd_mux = {16'h0000, pb_lo_r};
		default:            rd_mux = 32'h00000000;
	endcase
end

// One wait cycle per access keeps the read path registered
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		ack_r   <= 1'b0;
		rdata_r <= 32'h00000000;
	end else begin
		ack_r <= bus_req & ~ack_r;
		// Capture read data in the wait cycle
		if (avs_read & ~ack_r) begin
			rdata_r <= rd_mux;
		end
	end
end

// Only rstn loads the power-on values into these; no other reset source reaches them
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		pa_up_r  <= `PPFS_RST_PA_UPPER;
		pa_lo_r  <= `PPFS_RST_PA_LOWER;
		pb_dir_r <= `PPFS_RST_PB_DIR;
		pb_up_r  <= `PPFS_RST_PB_UPPER;
		pb_lo_r  <= `PPFS_RST_PB_LOWER;
	end else if (wr_go) begin
		case (avs_address)
			`PPFS_OFS_PA_UPPER: begin
				pa_up_r <= merge16(pa_up_r, avs_writedata, avs_byteenable)
					| `PPFS_RSV_PA_UPPER;
			end
			`PPFS_OFS_PA_LOWER: begin
				pa_lo_r <= merge16(pa_lo_r, avs_writedata, avs_byteenable)
					| `PPFS_RSV_PA_LOWER;
			end
			`PPFS_OFS_PB_DIR: begin
				pb_dir_r <= merge16(pb_dir_r, avs_writedata, avs_byteenable);
			end
			`PPFS_OFS_PB_UPPER: begin
				pb_up_r <= merge16(pb_up_r, avs_writedata, avs_byteenable);
			end
			`PPFS_OFS_PB_LOWER: begin
				pb_lo_r <= merge16(pb_lo_r, avs_writedata, avs_byteenable);
			end
			default: begin
				// Unmapped write is dropped
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Port A multiplexing

wire [1:0] s15 = pa_up_r[`PPFS_PA15_LSB +: 2];
wire [1:0] s14 = pa_up_r[`PPFS_PA14_LSB +: 2];
wire [1:0] s13 = pa_up_r[`PPFS_PA13_LSB +: 2];
wire [1:0] s12 = pa_up_r[`PPFS_PA12_LSB +: 2];
wire [1:0] s11 = pa_up_r[`PPFS_PA11_LSB +: 2];
wire [1:0] s10 = pa_up_r[`PPFS_PA10_LSB +: 2];
wire [1:0] s9  = pa_up_r[`PPFS_PA9_LSB +: 2];
wire [1:0] s3  = pa_lo_r[`PPFS_PA3_LSB +: 2];
wire [1:0] s2  = pa_lo_r[`PPFS_PA2_LSB +: 2];
wire [1:0] s1  = pa_lo_r[`PPFS_PA1_LSB +: 2];
wire [1:0] s0  = pa_lo_r[`PPFS_PA0_LSB +: 2];
reg  [15:0] pa_o_nxt;    // Pin drive value
reg  [15:0] pa_e_nxt;    // Pin drive enable
reg  [15:0] pa_g_nxt;    // Pin in general I/O

// Default every pin to general I/O; reserved codes fall through to it
always @* begin
	pa_o_nxt = pa_gpio_dout;
	pa_e_nxt = pa_dir;
	pa_g_nxt = 16'hFFFF;
	// Pin 15: inputs only
	if (s15 == `PPFS_SEL_F1 || s15 == `PPFS_SEL_F3) begin
		pa_e_nxt[15] = 1'b0;
		pa_g_nxt[15] = 1'b0;
	end
	// Pin 14: irq input or dma acknowledge
	case (s14)
		`PPFS_SEL_F1: begin
			pa_e_nxt[14] = 1'b0;
			pa_g_nxt[14] = 1'b0;
		end
		`PPFS_SEL_F3: begin
			pa_o_nxt[14] = dma_acknowledge_out_1;
			pa_e_nxt[14] = 1'b1;
			pa_g_nxt[14] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 13: every function is an input
	if (s13 != `PPFS_SEL_GPIO) begin
		pa_e_nxt[13] = 1'b0;
		pa_g_nxt[13] = 1'b0;
	end
	// Pin 12: two inputs or dma acknowledge
	case (s12)
		`PPFS_SEL_F1, `PPFS_SEL_F2: begin
			pa_e_nxt[12] = 1'b0;
			pa_g_nxt[12] = 1'b0;
		end
		`PPFS_SEL_F3: begin
			pa_o_nxt[12] = dma_acknowledge_out_0;
			pa_e_nxt[12] = 1'b1;
			pa_g_nxt[12] = 1'b0;
		end
		default: begin
			// General I/O
		end
	endcase
	// Pin 11: parity turns round under bus control
	case (s11)
		`PPFS_SEL_F1: begin
			pa_o_nxt[11] = upper_parity_bit_drv;
			pa_e_nxt[11] = upper_parity_bit_oe;
			pa_g_nxt[11] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_o_nxt[11] = timer1_capcomp_b_drv;
			pa_g_nxt[11] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 10: same shape as pin 11
	case (s10)
		`PPFS_SEL_F1: begin
			pa_o_nxt[10] = lower_parity_bit_drv;
			pa_e_nxt[10] = lower_parity_bit_oe;
			pa_g_nxt[10] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_o_nxt[10] = timer1_capcomp_a_drv;
			pa_g_nxt[10] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 9: hold out, trigger in, irq out
	case (s9)
		`PPFS_SEL_F1: begin
			pa_o_nxt[9] = address_hold_out;
			pa_e_nxt[9] = 1'b1;
			pa_g_nxt[9] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_e_nxt[9] = 1'b0;
			pa_g_nxt[9] = 1'b0;
		end
		`PPFS_SEL_F3: begin
			pa_o_nxt[9] = interrupt_request_out;
			pa_e_nxt[9] = 1'b1;
			pa_g_nxt[9] = 1'b0;
		end
		default: begin
			// General I/O
		end
	endcase
	// Pin 8: bus request input
	if (pa_up_r[`PPFS_PA8_BIT]) begin
		pa_e_nxt[8] = 1'b0;
		pa_g_nxt[8] = 1'b0;
	end
	// Pins 7..4: bus strobes, always driven
	if (pa_lo_r[`PPFS_PA7_BIT]) begin
		pa_o_nxt[7] = bus_grant_ack;
		pa_e_nxt[7] = 1'b1;
		pa_g_nxt[7] = 1'b0;
	end
	if (pa_lo_r[`PPFS_PA6_BIT]) begin
		pa_o_nxt[6] = read_strobe;
		pa_e_nxt[6] = 1'b1;
		pa_g_nxt[6] = 1'b0;
	end
	if (pa_lo_r[`PPFS_PA5_BIT]) begin
		pa_o_nxt[5] = upper_write_strobe;
		pa_e_nxt[5] = 1'b1;
		pa_g_nxt[5] = 1'b0;
	end
	if (pa_lo_r[`PPFS_PA4_BIT]) begin
		pa_o_nxt[4] = lower_write_strobe;
		pa_e_nxt[4] = 1'b1;
		pa_g_nxt[4] = 1'b0;
	end
	// Pin 3: chip select or wait input
	case (s3)
		`PPFS_SEL_F1: begin
			pa_o_nxt[3] = chip_select_7;
			pa_e_nxt[3] = 1'b1;
			pa_g_nxt[3] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_e_nxt[3] = 1'b0;
			pa_g_nxt[3] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 2: chip select or timer channel 0 b
	case (s2)
		`PPFS_SEL_F1: begin
			pa_o_nxt[2] = chip_select_6;
			pa_e_nxt[2] = 1'b1;
			pa_g_nxt[2] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_o_nxt[2] = timer0_capcomp_b_drv;
			pa_g_nxt[2] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 1: chip select or row strobe
	case (s1)
		`PPFS_SEL_F1: begin
			pa_o_nxt[1] = chip_select_5;
			pa_e_nxt[1] = 1'b1;
			pa_g_nxt[1] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_o_nxt[1] = row_addr_strobe;
			pa_e_nxt[1] = 1'b1;
			pa_g_nxt[1] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
	// Pin 0: chip select or timer channel 0 a
	case (s0)
		`PPFS_SEL_F1: begin
			pa_o_nxt[0] = chip_select_4;
			pa_e_nxt[0] = 1'b1;
			pa_g_nxt[0] = 1'b0;
		end
		`PPFS_SEL_F2: begin
			pa_o_nxt[0] = timer0_capcomp_a_drv;
			pa_g_nxt[0] = 1'b0;
		end
		default: begin
			// General I/O, reserved included
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Port B multiplexing, one slice per pin

wire [31:0] pb_sel = {pb_up_r, pb_lo_r};
wire [15:0] pb_o_nxt;    // Pin drive value
wire [15:0] pb_e_nxt;    // Pin drive enable
wire [15:0] pb_g_nxt;    // Pin in general I/O
wire [7:0]  pbt_nxt;     // Timer capture routes

genvar gi;
generate
	for (gi = 0; gi < 16; gi = gi + 1) begin : g_pb
		wire [1:0] s = pb_sel[2*gi +: 2];
		wire       pat = (s == `PPFS_SEL_F3);
		// Code 01 is reserved below pin 12, code 10 above pin 13
		wire       rsv = (s == `PPFS_SEL_F1 && gi < 12) ||
			(s == `PPFS_SEL_F2 && gi > 13);
		wire       gpio = (s == `PPFS_SEL_GPIO) || rsv;
		wire       f2v;      // Function two drive value
		wire       f2e;      // Function two drive enable
		if (gi < 8) begin : g_tmr
			assign f2v = pb_timer_drv[gi];
			assign f2e = pb_dir_r[gi];
			assign pbt_nxt[gi] = (s == `PPFS_SEL_F2) ? pb_pin_lvl[gi] : 1'b0;
		end else if (gi == 9 || gi == 11) begin : g_tx
			assign f2v = (gi == 9) ? serial_tx_ch0 : serial_tx_ch1;
			assign f2e = 1'b1;
		end else if (gi == 12 || gi == 13) begin : g_sck
			assign f2v = (gi == 12) ? serial_clock_ch0_drv : serial_clock_ch1_drv;
			assign f2e = pb_dir_r[gi];
		end else begin : g_in
			// Receive data and interrupts only listen
			assign f2v = 1'b0;
			assign f2e = 1'b0;
		end
		assign pb_o_nxt[gi] = pat ? pattern_out[gi] : gpio ? pb_gpio_dout[gi] : f2v;
		assign pb_e_nxt[gi] = pat ? 1'b1 : gpio ? pb_dir_r[gi] :
			(s == `PPFS_SEL_F2) ? f2e : 1'b0;
		assign pb_g_nxt[gi] = gpio;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Routed peripheral inputs; idle level when the pin is elsewhere

wire [7:0] irq_nxt = {
	(pb_sel[30 +: 2] == `PPFS_SEL_F1) ? pb_pin_lvl[15] : 1'b1,
	(pb_sel[28 +: 2] == `PPFS_SEL_F1) ? pb_pin_lvl[14] : 1'b1,
	(pb_sel[26 +: 2] == `PPFS_SEL_F1) ? pb_pin_lvl[13] : 1'b1,
	(pb_sel[24 +: 2] == `PPFS_SEL_F1) ? pb_pin_lvl[12] : 1'b1,
	(s15 == `PPFS_SEL_F1) ? pa_pin_lvl[15] : 1'b1,
	(s14 == `PPFS_SEL_F1) ? pa_pin_lvl[14] : 1'b1,
	(s13 == `PPFS_SEL_F1) ? pa_pin_lvl[13] : 1'b1,
	(s12 == `PPFS_SEL_F1) ? pa_pin_lvl[12] : 1'b1};

// Pin and route flops; outputs come straight from these
reg [15:0] pa_o_r, pa_e_r, pa_g_r, pb_o_r, pb_e_r, pb_g_r;
reg [7:0]  irq_r, pbt_r;
reg        dma_request_in_1_r, dma_request_in_0_r, timer_ext_clock_a_r, timer_ext_clock_b_r, t1a_r, t1b_r, t0a_r, t0b_r;
reg        dph_r, dpl_r, trg_r, bus_request_in_r, wait_r, serial_clock_ch1_r, serial_clock_ch0_r, rx1_r, rx0_r;

// Registered view adds one cycle from select or pin to port
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		pa_o_r  <= 16'h0000;
		pa_e_r  <= 16'h0000;
		pa_g_r  <= 16'h0000;
		pb_o_r  <= 16'h0000;
		pb_e_r  <= 16'h0000;
		pb_g_r  <= 16'h0000;
		irq_r   <= 8'hFF;
		pbt_r   <= 8'h00;
		dma_request_in_1_r <= 1'b1;
		dma_request_in_0_r <= 1'b1;
		timer_ext_clock_a_r <= 1'b0;
		timer_ext_clock_b_r <= 1'b0;
		t1a_r   <= 1'b0;
		t1b_r   <= 1'b0;
		t0a_r   <= 1'b0;
		t0b_r   <= 1'b0;
		dph_r   <= 1'b0;
		dpl_r   <= 1'b0;
		trg_r   <= 1'b1;
		bus_request_in_r  <= 1'b1;
		wait_r  <= 1'b1;
		serial_clock_ch1_r  <= 1'b0;
		serial_clock_ch0_r  <= 1'b0;
		rx1_r   <= 1'b1;
		rx0_r   <= 1'b1;
	end else begin
		pa_o_r  <= pa_o_nxt;
		pa_e_r  <= pa_e_nxt;
		pa_g_r  <= pa_g_nxt;
		pb_o_r  <= pb_o_nxt;
		pb_e_r  <= pb_e_nxt;
		pb_g_r  <= pb_g_nxt;
		irq_r   <= irq_nxt;
		pbt_r   <= pbt_nxt;
		dma_request_in_1_r <= (s15 == `PPFS_SEL_F3) ? pa_pin_lvl[15] : 1'b1;
		dma_request_in_0_r <= (s13 == `PPFS_SEL_F3) ? pa_pin_lvl[13] : 1'b1;
		timer_ext_clock_b_r <= (s13 == `PPFS_SEL_F2) ? pa_pin_lvl[13] : 1'b0;
		timer_ext_clock_a_r <= (s12 == `PPFS_SEL_F2) ? pa_pin_lvl[12] : 1'b0;
		dph_r   <= (s11 == `PPFS_SEL_F1) ? pa_pin_lvl[11] : 1'b0;
		t1b_r   <= (s11 == `PPFS_SEL_F2) ? pa_pin_lvl[11] : 1'b0;
		dpl_r   <= (s10 == `PPFS_SEL_F1) ? pa_pin_lvl[10] : 1'b0;
		t1a_r   <= (s10 == `PPFS_SEL_F2) ? pa_pin_lvl[10] : 1'b0;
		trg_r   <= (s9 == `PPFS_SEL_F2) ? pa_pin_lvl[9] : 1'b1;
		bus_request_in_r  <= pa_up_r[`PPFS_PA8_BIT] ? pa_pin_lvl[8] : 1'b1;
		wait_r  <= (s3 == `PPFS_SEL_F2) ? pa_pin_lvl[3] : 1'b1;
		t0b_r   <= (s2 == `PPFS_SEL_F2) ? pa_pin_lvl[2] : 1'b0;
		t0a_r   <= (s0 == `PPFS_SEL_F2) ? pa_pin_lvl[0] : 1'b0;
		serial_clock_ch1_r  <= (pb_sel[26 +: 2] == `PPFS_SEL_F2) ? pb_pin_lvl[13] : 1'b0;
		serial_clock_ch0_r  <= (pb_sel[24 +: 2] == `PPFS_SEL_F2) ? pb_pin_lvl[12] : 1'b0;
		rx1_r   <= (pb_sel[20 +: 2] == `PPFS_SEL_F2) ? pb_pin_lvl[10] : 1'b1;
		rx0_r   <= (pb_sel[16 +: 2] == `PPFS_SEL_F2) ? pb_pin_lvl[8] : 1'b1;
	end
end

assign pa_pin_drv           = pa_o_r;
assign pa_pin_oe            = pa_e_r;
assign pa_gpio_mode         = pa_g_r;
assign pb_pin_drv           = pb_o_r;
assign pb_pin_oe            = pb_e_r;
assign pb_gpio_mode         = pb_g_r;
assign ext_interrupt        = irq_r;
assign pb_timer_rcv         = pbt_r;
assign dma_request_in_1     = dma_request_in_1_r;
assign dma_request_in_0     = dma_request_in_0_r;
assign timer_ext_clock_a    = timer_ext_clock_a_r;
assign timer_ext_clock_b    = timer_ext_clock_b_r;
assign timer1_capcomp_a_rcv = t1a_r;
assign timer1_capcomp_b_rcv = t1b_r;
assign timer0_capcomp_a_rcv = t0a_r;
assign timer0_capcomp_b_rcv = t0b_r;
assign upper_parity_bit_rcv = dph_r;
assign lower_parity_bit_rcv = dpl_r;
assign converter_trigger_in = trg_r;
assign bus_request_in       = bus_request_in_r;
assign wait_state_in        = wait_r;
assign serial_clock_ch1_rcv = serial_clock_ch1_r;
assign serial_clock_ch0_rcv = serial_clock_ch0_r;
assign serial_rx_ch1        = rx1_r;
assign serial_rx_ch0        = rx0_r;

endmodule // ppfs_top

// ### tb/ppfs_monitor.sv
`include "ppfs_defines.vh"
module ppfs_monitor (
	input logic        clock,
	input logic        rstn,
	input logic [4:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0]  avs_byteenable,
	input logic [31:0] avs_readdata,
	input logic        avs_waitrequest,
	input logic [15:0] pa_pin_drv,
	input logic [15:0] pa_pin_oe,
	input logic [15:0] pa_gpio_mode,
	input logic [15:0] pb_pin_oe,
	input logic [15:0] pb_gpio_mode,
	input logic [15:0] port_b_direction,
	input logic [7:0]  ext_interrupt,
	input logic        bus_request_in,
	input logic        dma_acknowledge_out_1,
	input logic        dma_acknowledge_out_0,
	input logic        read_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and reset are stated once
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////
	// Completed bus steps
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	sequence s_dir_wr;
		avs_write && !avs_waitrequest && avs_address == `PPFS_OFS_PB_DIR
			&& avs_byteenable[1:0] == 2'h3;
	endsequence
	////////////////////////////////////////////////////////////
	a_upper_rsv: assert property (s_rd_done ##0 avs_address == `PPFS_OFS_PA_UPPER
		|-> avs_readdata[1]) else $error("upper reserved bit read zero");
	a_lower_rsv: assert property (s_rd_done ##0 avs_address == `PPFS_OFS_PA_LOWER
		|-> (avs_readdata[15:0] & 16'hAA00) == 16'hAA00) else $error("lower reserved bits");
	a_dir_write: assert property (s_dir_wr |=> port_b_direction == $past(avs_writedata[15:0]))
		else $error("direction write lost");
	a_dir_pin: assert property (pb_gpio_mode[0] |-> pb_pin_oe[0] == $past(port_b_direction[0]))
		else $error("gpio enable not from direction");
	a_ack_one: assert property (pa_pin_oe[14] && !pa_gpio_mode[14]
		|-> pa_pin_drv[14] == $past(dma_acknowledge_out_1)) else $error("pin 14 ack drive");
	a_ack_zero: assert property (pa_pin_oe[12] && !pa_gpio_mode[12]
		|-> pa_pin_drv[12] == $past(dma_acknowledge_out_0)) else $error("pin 12 ack drive");
	a_read_strobe: assert property (pa_pin_oe[6] && !pa_gpio_mode[6]
		|-> pa_pin_drv[6] == $past(read_strobe)) else $error("pin 6 strobe drive");
	a_bus_request_in_idle: assert property (pa_gpio_mode[8] |-> bus_request_in)
		else $error("bus request not idle");
	a_irq_idle: assert property (pb_gpio_mode[15] |-> ext_interrupt[7])
		else $error("interrupt 7 not idle");
endmodule // ppfs_monitor
bind ppfs_top ppfs_monitor ppfs_monitor_i (.*);

// ### tb/ppfs_pin_model.sv
// Board side: drives every pin that the block leaves released
module ppfs_pin_model (
	input  logic [15:0] pa_pin_drv,
	input  logic [15:0] pa_pin_oe,
	input  logic [15:0] pb_pin_drv,
	input  logic [15:0] pb_pin_oe,
	input  logic [15:0] pa_board,
	input  logic [15:0] pb_board,
	output logic [15:0] pa_pin_lvl,
	output logic [15:0] pb_pin_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// Board yields where the block drives, so no contention
	assign pa_pin_lvl = (pa_pin_oe & pa_pin_drv) | (~pa_pin_oe & pa_board);
	assign pb_pin_lvl = (pb_pin_oe & pb_pin_drv) | (~pb_pin_oe & pb_board);
endmodule // ppfs_pin_model

// ### tb/tb_port_pin_function_select.sv
`include "ppfs_defines.vh"
module tb_port_pin_function_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rstn, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] pa_pin_lvl, pa_pin_drv, pa_pin_oe, pb_pin_lvl, pb_pin_drv, pb_pin_oe;
	logic [15:0] pa_dir, pa_gpio_dout, pa_gpio_mode, pb_gpio_dout, pb_gpio_mode;
	logic [15:0] port_b_direction, pattern_out, pa_board, pb_board, stim, prev;
	logic [7:0]  ext_interrupt, pb_timer_drv, pb_timer_rcv;
	logic        dma_request_in_1, dma_request_in_0, dma_acknowledge_out_1;
	logic        dma_acknowledge_out_0, timer_ext_clock_a, timer_ext_clock_b;
	logic        timer1_capcomp_a_drv, timer1_capcomp_a_rcv, timer1_capcomp_b_drv;
	logic        timer1_capcomp_b_rcv, timer0_capcomp_a_drv, timer0_capcomp_a_rcv;
	logic        timer0_capcomp_b_drv, timer0_capcomp_b_rcv, upper_parity_bit_drv;
	logic        upper_parity_bit_oe, upper_parity_bit_rcv, lower_parity_bit_drv;
	logic        lower_parity_bit_oe, lower_parity_bit_rcv, address_hold_out;
	logic        converter_trigger_in, interrupt_request_out, bus_request_in;
	logic        bus_grant_ack, read_strobe, upper_write_strobe, lower_write_strobe;
	logic        chip_select_7, chip_select_6, chip_select_5, chip_select_4;
	logic        wait_state_in, row_addr_strobe, serial_clock_ch1_drv, serial_clock_ch1_rcv;
	logic        serial_clock_ch0_drv, serial_clock_ch0_rcv, serial_tx_ch1, serial_tx_ch0;
	logic        serial_rx_ch1, serial_rx_ch0;
	int          fail_count = 0;
	int          num_checks = 0;
	////////////////////////////////////////////////////////////
	// Peripheral drives all follow one shifting pattern
	assign {dma_acknowledge_out_1, dma_acknowledge_out_0, address_hold_out, row_addr_strobe,
		read_strobe, bus_grant_ack, upper_write_strobe, lower_write_strobe, chip_select_7,
		chip_select_6, chip_select_5, chip_select_4, interrupt_request_out, serial_tx_ch1,
		serial_tx_ch0, upper_parity_bit_drv} = stim;
	assign {timer1_capcomp_a_drv, timer1_capcomp_b_drv, timer0_capcomp_a_drv,
		timer0_capcomp_b_drv, lower_parity_bit_drv, serial_clock_ch1_drv,
		serial_clock_ch0_drv, upper_parity_bit_oe, lower_parity_bit_oe} = ~stim[8:0];
	assign pattern_out = {stim[7:0], stim[15:8]};
	assign pb_timer_drv = stim[7:0];
	assign pa_gpio_dout = stim;
	assign pb_gpio_dout = ~stim;
	assign pa_dir = 16'h0000;
	ppfs_top ppfs_top_i (.*);
	ppfs_pin_model ppfs_pin_model_i (.*);
	// Pattern steps every rising edge; prev is what the block last sampled
	always @(posedge clock) begin
		prev <= stim;
		stim <= {stim[14:0], ~(stim[15] ^ stim[3])};
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Held until waitrequest is seen low, released after that edge
	task bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			fail_count++;
			final_report;
		end
		q = avs_readdata[15:0];
		@(posedge clock);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd_chk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		check(q, exp);
	endtask
	////////////////////////////////////////////////////////////
	// Power-on values and the pin roles they select
	task t_reset_vals;
		rd_chk(`PPFS_OFS_PA_UPPER, 16'h3302);
		rd_chk(`PPFS_OFS_PA_LOWER, 16'hFF95);
		rd_chk(`PPFS_OFS_PB_DIR, 16'h0000);
		rd_chk(`PPFS_OFS_PB_UPPER, 16'h0000);
		rd_chk(`PPFS_OFS_PB_LOWER, 16'h0000);
		rd_chk(5'h14, 16'h0000);
		check(pa_pin_oe, 16'h50F7);
		check(pa_gpio_mode, 16'hAF00);
		check(pb_pin_oe, 16'h0000);
	endtask
	// Software keeps ones in reserved places; they read back as ones
	task t_readback;
		wr(`PPFS_OFS_PA_UPPER, 16'h0002);
		rd_chk(`PPFS_OFS_PA_UPPER, 16'h0002);
		wr(`PPFS_OFS_PA_LOWER, 16'hAA00);
		rd_chk(`PPFS_OFS_PA_LOWER, 16'hAA00);
		wr(`PPFS_OFS_PB_UPPER, 16'h3CF0);
		rd_chk(`PPFS_OFS_PB_UPPER, 16'h3CF0);
		wr(5'h14, 16'hFFFF);
		rd_chk(5'h14, 16'h0000);
		repeat (2) @(negedge clock);
		check(pa_gpio_mode, 16'hFFFF);
	endtask
	// Row strobe, wait input, request input, reserved code
	task t_port_a;
		wr(`PPFS_OFS_PA_UPPER, 16'h0C02);
		wr(`PPFS_OFS_PA_LOWER, 16'hAA8B);
		repeat (2) @(negedge clock);
		check(pa_pin_oe[1], 1'b1);
		check(pa_pin_drv[1], prev[12]);
		check(pa_gpio_mode, 16'hDFF5);
		@(posedge clock) pa_board <= 16'h2008;
		repeat (3) @(negedge clock);
		check({wait_state_in, dma_request_in_0}, 2'h3);
		@(posedge clock) pa_board <= 16'h0000;
		repeat (3) @(negedge clock);
		check({wait_state_in, dma_request_in_0}, 2'h0);
	endtask
	// Direction is ignored on pattern and interrupt pins; pattern and interrupt
	task t_port_b;
		wr(`PPFS_OFS_PB_DIR, 16'hFFFF);
		wr(`PPFS_OFS_PB_LOWER, 16'h0000);
		wr(`PPFS_OFS_PB_UPPER, 16'h4003);
		repeat (2) @(negedge clock);
		check(pb_pin_drv[8], prev[0]);
		check(pb_pin_oe, 16'h7FFF);
		check(pb_gpio_mode, 16'h7EFF);
		check(port_b_direction, 16'hFFFF);
		@(posedge clock) pb_board <= 16'h0000;
		repeat (3) @(negedge clock);
		check(ext_interrupt[7], 1'b0);
		@(posedge clock) pb_board <= 16'h8000;
		repeat (3) @(negedge clock);
		check(ext_interrupt[7], 1'b1);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h3;
		pa_board = 16'h0000;
		pb_board = 16'h0000;
		stim = 16'h1234;
		prev = 16'h0000;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_reset_vals;
		t_readback;
		t_port_a;
		t_port_b;
		final_report;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		final_report;
	end
endmodule // tb_port_pin_function_select
